// file: shared/gpps_defines.svh
// Register offsets, field positions and reset values of the pin-steering GPIO port
`ifndef GPPS_DEFINES_SVH
`define GPPS_DEFINES_SVH

// Byte addresses of the register words
`define GPPS_OFF_PIN_VALUE      12'h000
`define GPPS_OFF_OUTPUT_LATCH   12'h004
`define GPPS_OFF_DIRECTION      12'h008
`define GPPS_OFF_ANALOG_SELECT  12'h00c
`define GPPS_OFF_PIN_STEERING   12'h010

// Reset values
`define GPPS_RST_DIRECTION      8'hff
`define GPPS_RST_OUTPUT_LATCH   8'h00
`define GPPS_RST_ANALOG_SELECT  8'h2f
`define GPPS_RST_PIN_STEERING   8'h00

// Implemented bit masks
`define GPPS_MASK_ANALOG_SELECT 8'h2f
`define GPPS_MASK_PIN_STEERING  8'h03

// Field positions of the steering register
`define GPPS_BIT_CCP_PIN_SELECT 0
`define GPPS_BIT_TMR_CLK_SELECT 1

// Pin that carries clock and oscillator outputs
`define GPPS_PIN_SIX            3'h6

// Width of the raw input bundle (8 port pins, 2 timer pins, 2 capture pins)
`define GPPS_IN_WIDTH           12

`endif

// file: shared/gpps_pkg.sv
// Types shared by the pin-steering GPIO port
package gpps_pkg;

    // Register selected by an APB address
    typedef enum logic [2:0] {
        SEL_NONE          = 3'h0,
        SEL_PIN_VALUE     = 3'h1,
        SEL_OUTPUT_LATCH  = 3'h2,
        SEL_DIRECTION     = 3'h3,
        SEL_ANALOG_SELECT = 3'h4,
        SEL_PIN_STEERING  = 3'h5
    } gpps_reg_sel_type;

endpackage

// file: logic/gpps_port.sv
// Eight-pin GPIO port with analog select, pin steering and an APB register slave
//
// Function
// R1 - Eight pins, each with direction, output latch and pin-level read bit.
// R2 - Direction one tri-states the pin; zero drives the latched value.
// R3 - Writing the pin-value register updates the output latch.
// R4 - Latch register reads the latch; pin-value register reads live pin levels.
// R5 - Port writes are read-modify-write: sampled pin levels merged with written bits.
// R6 - An enabled peripheral output takes the pin away from the latch; still readable.
// R7 - Direction bits control the drivers even in analog mode.
// R8 - Software keeps direction set to input on analog pins.
// R9 - Analog-selected pins read zero digitally; analog functions are enabled.
// R10 - Analog select disables the pin's digital input buffer.
// R11 - Analog select does not affect digital output driving.
// R12 - Every reset sets all implemented analog-select bits to one.
// R13 - Software clears analog select before using a pin as digital input.
// R14 - Steering bit 1 picks timer clock input from first or second pin.
// R15 - Steering bit 0 puts capture/compare on primary or alternate pin.
// R16 - Steering leaves direction alone; overrides follow; unselected pin untouched.
// R17 - Steering bits 7 to 2 read zero; implemented bits reset to zero.
// R18 - Pin six priority: clock output, oscillator output, then latch.
// R19 - Only pins 5 and 3 to 0 have analog select; others read zero.
// R20 - All direction bits reset to one, all pins tri-stated inputs.
// R21 - Writes act at the strobe edge; reads return values sampled in the setup cycle.
// R22 - Pin inputs are synchronised on the core clock before being read.
`timescale 1ns/1ps
`include "gpps_defines.svh"

module gpps_port (
    input  wire logic        MCLK,              // Core clock, 100 MHz
    input  wire logic        RST_N,             // Asynchronous reset, active low
    // APB slave
    input  wire logic        PSEL,              // Slave select
    input  wire logic        PENABLE,           // Access phase
    input  wire logic        PWRITE,            // Write when high
    input  wire logic [11:0] PADDR,             // Byte address
    input  wire logic [31:0] PWDATA,            // Write data
    input  wire logic [3:0]  PSTRB,             // Byte strobes
    output logic      [31:0] PRDATA,            // Read data
    output logic             PREADY,            // Transfer ready
    output logic             PSLVERR,           // Unmapped address
    // Port pins
    input  wire logic [7:0]  PORT_IN,           // Pin levels
    output logic      [7:0]  PORT_OUT,          // Pin drive values
    output logic      [7:0]  PORT_OE_N,         // Low while driving
    output logic      [7:0]  ANALOG_ENABLE,     // Analog function enable
    output logic      [7:0]  INPUT_BUFFER_OFF,  // Digital input buffer off
    // Pin six output sources
    input  wire logic        CLOCK_OUTPUT_FUNCTION_EN,         // Clock output enabled
    input  wire logic        CLOCK_OUTPUT_FUNCTION_VAL,        // Clock output level
    input  wire logic        OSCOUT_EN,         // Oscillator output enabled
    input  wire logic        OSCOUT_VAL,        // Oscillator output level
    // Timer clock input steering
    input  wire logic        TMR_CLK_PIN_FIRST, // First alternate pin level
    input  wire logic        TMR_CLK_PIN_SECOND,// Second alternate pin level
    output logic             TIMER_CLOCK_INPUT, // Selected timer clock
    // Capture/compare steering
    input  wire logic        CCP_OUT_EN,        // Peripheral owns pin output
    input  wire logic        CCP_OUT_VAL,       // Compare output level
    output logic             CCP_CAPTURE_IN,    // Selected capture level
    input  wire logic        CCP_PRI_IN,        // Primary pin level
    input  wire logic        CCP_PRI_PORT_OUT,  // Primary pin port latch
    input  wire logic        CCP_PRI_PORT_OE_N, // Primary pin port enable
    output logic             CCP_PRI_OUT,       // Primary pin drive
    output logic             CCP_PRI_OE_N,      // Primary pin enable, low drives
    input  wire logic        CCP_ALT_IN,        // Alternate pin level
    input  wire logic        CCP_ALT_PORT_OUT,  // Alternate pin port latch
    input  wire logic        CCP_ALT_PORT_OE_N, // Alternate pin port enable
    output logic             CCP_ALT_OUT,       // Alternate pin drive
    output logic             CCP_ALT_OE_N       // Alternate pin enable, low drives
);

    // R1 - per-pin register bits
    logic [7:0]                   direction;
    logic [7:0]                   output_latch;
    logic [7:0]                   analog_select;
    logic [7:0]                   pin_steering;

    // Input synchroniser chain
    logic [`GPPS_IN_WIDTH-1:0]    in_raw;
    logic [`GPPS_IN_WIDTH-1:0]    sync_a;
    logic [`GPPS_IN_WIDTH-1:0]    sync_b;
    logic [`GPPS_IN_WIDTH-1:0]    sync_c;
    logic [`GPPS_IN_WIDTH-1:0]    in_level;

    // Bus decode
    gpps_pkg::gpps_reg_sel_type   sel;
    logic                         setup_phase;
    logic                         wr_take;
    logic                         lane0;
    logic [7:0]                   pin_level;
    logic [7:0]                   next_rdata;
    logic [7:0]                   next_port_out;
    logic [7:0]                   next_port_oe_n;
    logic                         ccp_on_alt;
    logic                         tmr_on_second;

    // Address to register decode
    function automatic gpps_pkg::gpps_reg_sel_type decode(input logic [11:0] addr);
        if (addr == `GPPS_OFF_PIN_VALUE) begin
            decode = gpps_pkg::SEL_PIN_VALUE;
        end else if (addr == `GPPS_OFF_OUTPUT_LATCH) begin
            decode = gpps_pkg::SEL_OUTPUT_LATCH;
        end else if (addr == `GPPS_OFF_DIRECTION) begin
            decode = gpps_pkg::SEL_DIRECTION;
        end else if (addr == `GPPS_OFF_ANALOG_SELECT) begin
            decode = gpps_pkg::SEL_ANALOG_SELECT;
        end else if (addr == `GPPS_OFF_PIN_STEERING) begin
            decode = gpps_pkg::SEL_PIN_STEERING;
        end else begin
            decode = gpps_pkg::SEL_NONE;
        end
    endfunction

    // Bundle of all external pin-level inputs: port, timer and capture pins
    assign in_raw = {CCP_ALT_IN, CCP_PRI_IN, TMR_CLK_PIN_SECOND, TMR_CLK_PIN_FIRST, PORT_IN};

    // R22 - synchronise pin inputs
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            sync_a <= '0;
            sync_b <= '0;
            sync_c <= '0;
        end else begin
            sync_a <= in_raw;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // Accept a change once second and third stages agree
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            in_level <= '0;
        end else begin
            in_level <= (sync_b & sync_c) | (in_level & (sync_b ^ sync_c));
        end
    end

    // R9 R10 - analog pins read zero
    assign pin_level = in_level[7:0] & ~analog_select;

    // Bus phase decode
    assign sel         = decode(PADDR);
    assign setup_phase = PSEL && !PENABLE;
    // R21 - write acts at the completing edge
    assign wr_take     = PSEL && PENABLE && PREADY && PWRITE;
    assign lane0       = PSTRB[0];

    // Ready and error answered one cycle after setup
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= setup_phase;
            PSLVERR <= setup_phase && (sel == gpps_pkg::SEL_NONE);
        end
    end

    // R4 R21 - read data mux
    always_comb begin
        next_rdata = 8'h00;
        case (sel)
            gpps_pkg::SEL_PIN_VALUE:     next_rdata = pin_level;
            gpps_pkg::SEL_OUTPUT_LATCH:  next_rdata = output_latch;
            gpps_pkg::SEL_DIRECTION:     next_rdata = direction;
            // R19 - unimplemented analog bits read zero
            gpps_pkg::SEL_ANALOG_SELECT: next_rdata = analog_select & `GPPS_MASK_ANALOG_SELECT;
            // R17 - upper steering bits read zero
            gpps_pkg::SEL_PIN_STEERING:  next_rdata = pin_steering & `GPPS_MASK_PIN_STEERING;
            default:                     next_rdata = 8'h00;
        endcase
    end

    // Read data captured in the setup cycle
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            PRDATA <= 32'h0000_0000;
        end else if (setup_phase && !PWRITE) begin
            PRDATA <= {24'h00_0000, next_rdata};
        end
    end

    // Output latch register
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            output_latch <= `GPPS_RST_OUTPUT_LATCH;
        end else if (wr_take && (sel == gpps_pkg::SEL_PIN_VALUE
                                 || sel == gpps_pkg::SEL_OUTPUT_LATCH)) begin
            // R3 R5 - merge written lane over sampled pins
            output_latch <= lane0 ? PWDATA[7:0] : pin_level;
        end
    end

    // Direction register
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            // R20 - all pins start as inputs
            direction <= `GPPS_RST_DIRECTION;
        end else if (wr_take && lane0 && sel == gpps_pkg::SEL_DIRECTION) begin
            direction <= PWDATA[7:0];
        end
    end

    // Analog select register
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            // R12 - reset to analog mode
            analog_select <= `GPPS_RST_ANALOG_SELECT;
        end else if (wr_take && lane0 && sel == gpps_pkg::SEL_ANALOG_SELECT) begin
            // R19 - keep only implemented bits
            analog_select <= PWDATA[7:0] & `GPPS_MASK_ANALOG_SELECT;
        end
    end

    // Steering register
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            // R17 - steering resets to zero
            pin_steering <= `GPPS_RST_PIN_STEERING;
        end else if (wr_take && lane0 && sel == gpps_pkg::SEL_PIN_STEERING) begin
            pin_steering <= PWDATA[7:0] & `GPPS_MASK_PIN_STEERING;
        end
    end

    // Analog controls follow the select bits
    assign ANALOG_ENABLE    = analog_select;
    assign INPUT_BUFFER_OFF = analog_select;

    // Pin drive selection
    always_comb begin
        // R2 R7 R11 - direction alone gates the latch driver
        next_port_out  = output_latch;
        next_port_oe_n = direction;
        // R6 R18 - clock output, then oscillator, then latch
        if (CLOCK_OUTPUT_FUNCTION_EN) begin
            next_port_out[`GPPS_PIN_SIX]  = CLOCK_OUTPUT_FUNCTION_VAL;
            next_port_oe_n[`GPPS_PIN_SIX] = 1'b0;
        end else if (OSCOUT_EN) begin
            next_port_out[`GPPS_PIN_SIX]  = OSCOUT_VAL;
            next_port_oe_n[`GPPS_PIN_SIX] = 1'b0;
        end
    end

    // Registered pin drivers
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            PORT_OUT  <= 8'h00;
            PORT_OE_N <= 8'hff;
        end else begin
            PORT_OUT  <= next_port_out;
            PORT_OE_N <= next_port_oe_n;
        end
    end

    // Steering selects
    assign ccp_on_alt    = pin_steering[`GPPS_BIT_CCP_PIN_SELECT];
    assign tmr_on_second = pin_steering[`GPPS_BIT_TMR_CLK_SELECT];

    // R14 - timer clock input routing
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            TIMER_CLOCK_INPUT <= 1'b0;
        end else begin
            TIMER_CLOCK_INPUT <= tmr_on_second ? in_level[9] : in_level[8];
        end
    end

    // R15 - capture input routing
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            CCP_CAPTURE_IN <= 1'b0;
        end else begin
            CCP_CAPTURE_IN <= ccp_on_alt ? in_level[11] : in_level[10];
        end
    end

    // R16 - override only the selected pin, port values pass otherwise
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            CCP_PRI_OUT  <= 1'b0;
            CCP_PRI_OE_N <= 1'b1;
            CCP_ALT_OUT  <= 1'b0;
            CCP_ALT_OE_N <= 1'b1;
        end else begin
            CCP_PRI_OUT  <= (CCP_OUT_EN && !ccp_on_alt) ? CCP_OUT_VAL : CCP_PRI_PORT_OUT;
            CCP_PRI_OE_N <= (CCP_OUT_EN && !ccp_on_alt) ? 1'b0 : CCP_PRI_PORT_OE_N;
            CCP_ALT_OUT  <= (CCP_OUT_EN && ccp_on_alt) ? CCP_OUT_VAL : CCP_ALT_PORT_OUT;
            CCP_ALT_OE_N <= (CCP_OUT_EN && ccp_on_alt) ? 1'b0 : CCP_ALT_PORT_OE_N;
        end
    end

endmodule

// file: tb/gpps_chk.sv
// Concurrent checks on the pin-steering GPIO port boundary
`timescale 1ns/1ps

module gpps_chk (
    input wire logic        MCLK,             // Core clock
    input wire logic        RST_N,            // Async reset, low
    input wire logic        PSEL,             // Slave select
    input wire logic        PENABLE,          // Access phase
    input wire logic        PWRITE,           // Write when high
    input wire logic [11:0] PADDR,            // Byte address
    input wire logic [31:0] PRDATA,           // Read data
    input wire logic        PREADY,           // Transfer ready
    input wire logic        PSLVERR,          // Unmapped flag
    input wire logic [7:0]  PORT_OUT,         // Pin drive
    input wire logic [7:0]  PORT_OE_N,        // Low while driving
    input wire logic [7:0]  ANALOG_ENABLE,    // Analog select
    input wire logic [7:0]  INPUT_BUFFER_OFF, // Input buffer off
    input wire logic        CLOCK_OUTPUT_FUNCTION_EN,        // Clock output on
    input wire logic        CLOCK_OUTPUT_FUNCTION_VAL,       // Clock output level
    input wire logic        OSCOUT_EN,        // Oscillator output on
    input wire logic        OSCOUT_VAL        // Oscillator output level
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    logic setup;

    // Setup phase of an APB transfer
    assign setup = PSEL && !PENABLE;

    a_ready_after_setup: assert property (setup |=> PREADY)
        else $error("ready missing after setup");
    a_ready_single: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    a_unmapped_err: assert property (setup && !PWRITE && PADDR > 12'h010 |=> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped read not refused");
    a_mapped_no_err: assert property (setup && PADDR <= 12'h010 && PADDR[1:0] == 2'b00 |=> !PSLVERR)
        else $error("mapped access refused");
    a_steer_upper_zero: assert property (setup && !PWRITE && PADDR == 12'h010 |=> PRDATA[31:2] == 30'h0)
        else $error("steering upper bits not zero");
    a_analog_gaps: assert property ((ANALOG_ENABLE & 8'hd0) == 8'h00)
        else $error("analog bit set on pin without it");
    a_buffer_follows: assert property (INPUT_BUFFER_OFF == ANALOG_ENABLE)
        else $error("input buffer not tied to analog select");
    a_reset_state: assert property ($rose(RST_N) |-> ANALOG_ENABLE == 8'h2f && PORT_OE_N == 8'hff)
        else $error("wrong state after reset");
    a_clock_wins: assert property (CLOCK_OUTPUT_FUNCTION_EN |=> !PORT_OE_N[6] && PORT_OUT[6] == $past(CLOCK_OUTPUT_FUNCTION_VAL))
        else $error("clock output lost pin six");
    a_osc_next: assert property (!CLOCK_OUTPUT_FUNCTION_EN && OSCOUT_EN |=> !PORT_OE_N[6] && PORT_OUT[6] == $past(OSCOUT_VAL))
        else $error("oscillator output lost pin six");

    // Main scenarios reached
    c_write: cover property (setup && PWRITE);
    c_unmapped: cover property (setup && PADDR > 12'h010);
    c_both_sources: cover property (CLOCK_OUTPUT_FUNCTION_EN && OSCOUT_EN);
endmodule

// file: tb/gpps_pins.sv
// Model of the outside world on the eight port pins
`timescale 1ns/1ps

module gpps_pins (
    input  wire logic       clk,       // Core clock
    input  wire logic [7:0] port_out,  // Device drive values
    input  wire logic [7:0] port_oe_n, // Low while device drives
    input  wire logic [7:0] ext_val,   // Level from outside
    input  wire logic [7:0] ext_en,    // Outside drives these pins
    output logic      [7:0] port_in    // Resolved pin levels
);
    logic [7:0] float_pat;

    // Undriven pins toggle every cycle, so the port synchroniser holds their last accepted level
    always_ff @(posedge clk) begin
        float_pat <= (float_pat === 8'h55) ? 8'haa : 8'h55;
    end

    // device drive first, then outside, else noise
    always_comb begin
        port_in = (~port_oe_n & port_out) | (port_oe_n & ext_en & ext_val)
                | (port_oe_n & ~ext_en & float_pat);
    end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the pin-steering GPIO port
`timescale 1ns/1ps
`include "gpps_defines.svh"

module tb_top;
    typedef struct {
        logic [11:0] waddr;
        logic [7:0]  wdata;
        logic [11:0] raddr;
        logic [7:0]  exp;
    } gpps_row_type;
    logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, err, b;
    logic        ck_en, ck_val, osc_en, osc_val, tmr1, tmr2, tmr_in, ccp_en, ccp_val, ccp_cap;
    logic        pri_in, pri_pout, pri_poe, pri_out, pri_oe;
    logic        alt_in, alt_pout, alt_poe, alt_out, alt_oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [7:0]  port_in, port_out, port_oe_n, ana_en, buf_off, ext_val, ext_en;
    int          error_cnt = 0;
    int          num_checks = 0;
    gpps_row_type rows [7] = '{
        '{`GPPS_OFF_DIRECTION, 8'h5a, `GPPS_OFF_DIRECTION, 8'h5a},
        '{`GPPS_OFF_ANALOG_SELECT, 8'hff, `GPPS_OFF_ANALOG_SELECT, 8'h2f},
        '{`GPPS_OFF_ANALOG_SELECT, 8'h00, `GPPS_OFF_ANALOG_SELECT, 8'h00},
        '{`GPPS_OFF_PIN_STEERING, 8'hff, `GPPS_OFF_PIN_STEERING, 8'h03},
        '{`GPPS_OFF_OUTPUT_LATCH, 8'ha5, `GPPS_OFF_OUTPUT_LATCH, 8'ha5},
        '{`GPPS_OFF_PIN_VALUE, 8'h3c, `GPPS_OFF_OUTPUT_LATCH, 8'h3c},
        '{`GPPS_OFF_DIRECTION, 8'hff, `GPPS_OFF_DIRECTION, 8'hff}};
    gpps_row_type rst_rows [4] = '{
        '{12'h0, 8'h0, `GPPS_OFF_DIRECTION, 8'hff}, '{12'h0, 8'h0, `GPPS_OFF_OUTPUT_LATCH, 8'h00},
        '{12'h0, 8'h0, `GPPS_OFF_ANALOG_SELECT, 8'h2f}, '{12'h0, 8'h0, `GPPS_OFF_PIN_STEERING, 8'h00}};

    gpps_port gpps_port_inst (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PORT_IN(port_in), .PORT_OUT(port_out),
        .PORT_OE_N(port_oe_n), .ANALOG_ENABLE(ana_en), .INPUT_BUFFER_OFF(buf_off),
        .CLOCK_OUTPUT_FUNCTION_EN(ck_en), .CLOCK_OUTPUT_FUNCTION_VAL(ck_val), .OSCOUT_EN(osc_en), .OSCOUT_VAL(osc_val),
        .TMR_CLK_PIN_FIRST(tmr1), .TMR_CLK_PIN_SECOND(tmr2), .TIMER_CLOCK_INPUT(tmr_in),
        .CCP_OUT_EN(ccp_en), .CCP_OUT_VAL(ccp_val), .CCP_CAPTURE_IN(ccp_cap),
        .CCP_PRI_IN(pri_in), .CCP_PRI_PORT_OUT(pri_pout), .CCP_PRI_PORT_OE_N(pri_poe),
        .CCP_PRI_OUT(pri_out), .CCP_PRI_OE_N(pri_oe), .CCP_ALT_IN(alt_in),
        .CCP_ALT_PORT_OUT(alt_pout), .CCP_ALT_PORT_OE_N(alt_poe), .CCP_ALT_OUT(alt_out),
        .CCP_ALT_OE_N(alt_oe));
    gpps_pins gpps_pins_inst (.clk(mclk), .port_out(port_out), .port_oe_n(port_oe_n),
        .ext_val(ext_val), .ext_en(ext_en), .port_in(port_in));

    // Free-running core clock
    always #5 mclk = ~mclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer, held until ready is seen
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       input logic [3:0] s);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= wr ? s : 4'h0;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic final_report;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        final_report;
    end

    initial begin
        {mclk, rst_n, psel, penable, pwrite, ck_en, ck_val, osc_en, osc_val} = 9'h0;
        {tmr1, tmr2, ccp_en, ccp_val, pri_in, pri_pout, alt_in, alt_pout} = 8'h0;
        {pri_poe, alt_poe, paddr, pwdata, pstrb, ext_val, ext_en} = '0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, rows[i].waddr, rows[i].wdata, 4'h1);
            apb(1'b0, rows[i].raddr, 8'h00, 4'h1);
            chk(rd, {24'h0, rows[i].exp});
        end
        $display("register table done");
        ext_en <= 8'hff;
        ext_val <= 8'hc3;
        repeat (8) @(posedge mclk);
        apb(1'b0, `GPPS_OFF_PIN_VALUE, 8'h00, 4'h1);
        chk(rd, 32'hc3);
        apb(1'b1, `GPPS_OFF_ANALOG_SELECT, 8'h2f, 4'h1);
        repeat (8) @(posedge mclk);
        apb(1'b0, `GPPS_OFF_PIN_VALUE, 8'h00, 4'h1);
        chk(rd, 32'hc0);
        chk(buf_off, 8'h2f);
        chk(ana_en, 8'h2f);
        ext_en <= 8'h00;
        apb(1'b1, `GPPS_OFF_DIRECTION, 8'h00, 4'h1);
        apb(1'b1, `GPPS_OFF_OUTPUT_LATCH, 8'h5a, 4'h1);
        repeat (8) @(posedge mclk);
        chk({port_oe_n, port_out}, 16'h005a);
        apb(1'b0, `GPPS_OFF_PIN_VALUE, 8'h00, 4'h1);
        chk(rd, 32'h50);
        $display("pin path done");
        apb(1'b1, `GPPS_OFF_ANALOG_SELECT, 8'h00, 4'h1);
        apb(1'b1, `GPPS_OFF_DIRECTION, 8'hff, 4'h1);
        ext_en <= 8'hff; // Pin six held low so it never floats
        ext_val <= 8'h3c;
        repeat (8) @(posedge mclk);
        apb(1'b1, `GPPS_OFF_OUTPUT_LATCH, 8'h00, 4'h0);
        apb(1'b0, `GPPS_OFF_OUTPUT_LATCH, 8'h00, 4'h1);
        chk(rd, 32'h3c);
        ck_en <= 1'b1;
        ck_val <= 1'b1;
        osc_en <= 1'b1;
        repeat (3) @(posedge mclk);
        chk({port_oe_n[6], port_out[6]}, 2'b01);
        ck_en <= 1'b0;
        osc_val <= 1'b1;
        repeat (8) @(posedge mclk);
        apb(1'b0, `GPPS_OFF_PIN_VALUE, 8'h00, 4'h1);
        chk(rd[6], 1'b1);
        osc_en <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(port_oe_n[6], 1'b1);
        $display("pin six done");
        {tmr1, ccp_en, ccp_val, pri_in, pri_poe, alt_poe} <= 6'h3f;
        for (int s = 0; s < 2; s++) begin
            b = s[0];
            apb(1'b1, `GPPS_OFF_PIN_STEERING, {7'h0, b} * 8'h03, 4'h1);
            repeat (8) @(posedge mclk);
            chk({tmr_in, ccp_cap, pri_oe, pri_out, alt_oe, alt_out}, {~b, ~b, b, ~b, ~b, b});
        end
        apb(1'b0, `GPPS_OFF_DIRECTION, 8'h00, 4'h1);
        chk(rd, 32'hff);
        apb(1'b0, 12'h020, 8'h00, 4'h1);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        $display("steering and refusal done");
        rst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (rst_rows[i]) begin
            apb(1'b0, rst_rows[i].raddr, 8'h00, 4'h1);
            chk(rd, {24'h0, rst_rows[i].exp});
        end
        $display("mid-run reset done");
        final_report;
    end
endmodule

bind gpps_port gpps_chk gpps_chk_inst (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PORT_OUT(PORT_OUT), .PORT_OE_N(PORT_OE_N),
    .ANALOG_ENABLE(ANALOG_ENABLE), .INPUT_BUFFER_OFF(INPUT_BUFFER_OFF),
    .CLOCK_OUTPUT_FUNCTION_EN(CLOCK_OUTPUT_FUNCTION_EN), .CLOCK_OUTPUT_FUNCTION_VAL(CLOCK_OUTPUT_FUNCTION_VAL), .OSCOUT_EN(OSCOUT_EN),
    .OSCOUT_VAL(OSCOUT_VAL));
